/* bench/instrument_model.sv */
// Purpose: instrument side, closes the contact on command
// Assumes: open contact reads low (pulled down)
// Notes:   optional one-cycle bounces before the real closure
`timescale 1ns/1ps
`default_nettype none

module instrument_model (
  // clock
  input  wire logic       clock,
  // command from the bench
  input  wire logic       closeGo,
  input  wire logic [3:0] bounces,
  // contact pin
  output logic            contactIn
);
  initial contactIn = 1'b0;

  // condition met: bounce, hold closed, reopen
  always
  begin
    @(posedge clock);
    if (closeGo)
    begin
      repeat (bounces)
      begin
        contactIn <= 1'b1;
        @(posedge clock);
        contactIn <= 1'b0;
        repeat (2) @(posedge clock);
      end
      contactIn <= 1'b1;
      repeat (12) @(posedge clock);
      contactIn <= 1'b0;
    end
  end
endmodule // instrument_model

`default_nettype wire

/* bench/multi_bottle_composite_sequencer_tb.sv */
// Purpose: self-checking bench of the composite sequencer
// Assumes: short minute (20 cycles) and debounce (4 cycles)
// Notes:   bench plays pump and bus master
`timescale 1ns/1ps
`default_nettype none
`include "sampler_map.svh"

module multi_bottle_composite_sequencer_tb
  import sampler_pkg::*;
();
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        contactIn, spoutAdvance, sampleReq, programRunning;
  logic        bottleFullIn = 1'b0;
  logic        sampleDone = 1'b0;
  logic        closeGo = 1'b0;
  logic        pumpSent = 1'b0;
  logic        prevReq = 1'b0;
  logic [3:0]  bounces = 4'h0;
  logic [7:0]  bottleSel;
  logic [31:0] rd;
  logic [1:0]  rsp;
  axiReq_t     axiReq = '0;
  axiResp_t    axiResp;
  int bad_count, checked, cycles, advCount, baseAdv, gap, lastGap;
  int pumpBase, pumpCnt;
  int bottlesCfg = 1;
  logic [7:0]  tabAddr [7] = '{`ADDR_SPB, `ADDR_SPB, `ADDR_SPB,
    `ADDR_BOTTLES, `ADDR_OVERRIDE, `ADDR_OVERRIDE, `ADDR_OVERRIDE};
  logic [31:0] tabData [7] = '{32'h0, 32'h64, 32'h63, 32'h0,
    32'h6400, 32'h3c, 32'h0130};
  logic [31:0] tabExp  [7] = '{32'h1, 32'h1, 32'h63, 32'h18,
    32'h0, 32'h0, 32'h0130};

  composite_sequencer #(
    .MINUTE_CYCLES   (33'h14),
    .DEBOUNCE_CYCLES (20'h4)
  ) composite_sequencer_inst (
    .clock          (clock),
    .rst            (rst),
    .axiReq         (axiReq),
    .axiResp        (axiResp),
    .contactIn      (contactIn),
    .bottleFullIn   (bottleFullIn),
    .sampleDone     (sampleDone),
    .spoutAdvance   (spoutAdvance),
    .sampleReq      (sampleReq),
    .bottleSel      (bottleSel),
    .programRunning (programRunning)
  );

  instrument_model instrument_model_inst (
    .clock     (clock),
    .closeGo   (closeGo),
    .bounces   (bounces),
    .contactIn (contactIn)
  );

  // ==================
  // helpers
  function automatic int totalSamples(input int b, input int s);
    return b * s;
  endfunction

  function automatic logic [31:0] ovrMinutes(input logic [15:0] v);
    return v[15:8] * 60 + v[7:0];
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (bad_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hf;
    axiReq.bready <= 1'b1;
    b = 1'b0;
    while (!b)
    begin
      @(posedge clock);
      aw = axiReq.awvalid && axiResp.awready === 1'b1;
      w = axiReq.wvalid && axiResp.wready === 1'b1;
      b = axiResp.bvalid === 1'b1;
      rsp = axiResp.bresp;
      if (aw) axiReq.awvalid <= 1'b0;
      if (w) axiReq.wvalid <= 1'b0;
    end
    axiReq.bready <= 1'b0;
    @(posedge clock);
  endtask

  task automatic axiRead(input logic [7:0] a);
    logic ar, r;
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    axiReq.rready <= 1'b1;
    r = 1'b0;
    while (!r)
    begin
      @(posedge clock);
      ar = axiReq.arvalid && axiResp.arready === 1'b1;
      r = axiResp.rvalid === 1'b1;
      rd = axiResp.rdata;
      rsp = axiResp.rresp;
      if (ar) axiReq.arvalid <= 1'b0;
    end
    axiReq.rready <= 1'b0;
    @(posedge clock);
  endtask

  task automatic closure(input logic [3:0] n);
    bounces <= n;
    closeGo <= 1'b1;
    @(posedge clock);
    closeGo <= 1'b0;
  endtask

  task automatic startProg(input int b, input int s, input logic [15:0] o);
    bottlesCfg = b;
    axiWrite(`ADDR_MODE, 32'(`MODE_COMPOSITE));
    axiWrite(`ADDR_SPB, 32'(s));
    axiWrite(`ADDR_BOTTLES, 32'(b));
    axiWrite(`ADDR_OVERRIDE, 32'(o));
    baseAdv = advCount;
    axiWrite(`ADDR_CTRL, 32'h1);
    check(programRunning, 1'b1);
  endtask

  task automatic waitAdv(input int n);
    while (advCount - baseAdv < n) @(posedge clock);
  endtask

  task automatic waitIdle();
    while (programRunning !== 1'b0) @(posedge clock);
  endtask

  // clock and hang guard
  always #5 clock = ~clock;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      bad_count++;
      give_verdict();
    end
  end

  // pump: answers each sample request after a random delay
  always @(posedge clock)
  begin
    sampleDone <= 1'b0;
    if (sampleReq !== 1'b1)
    begin
      pumpSent <= 1'b0;
      pumpCnt <= pumpBase + int'($urandom % 4);
    end
    else if (!pumpSent)
    begin
      if (pumpCnt == 0)
      begin
        sampleDone <= 1'b1;
        pumpSent <= 1'b1;
      end
      else
        pumpCnt <= pumpCnt - 1;
    end
  end

  // spout watch: bottle order and gap after a finished sample
  always @(posedge clock)
  begin
    if (spoutAdvance === 1'b1)
    begin
      check(bottleSel, (advCount - baseAdv) % bottlesCfg);
      advCount++;
      lastGap = gap;
    end
    gap = (prevReq && sampleReq === 1'b0) ? 0 : gap + 1;
    prevReq = sampleReq;
  end

  // ==================
  // main sequence
  initial
  begin
    void'($urandom(12514));
    ticks(6);
    rst <= 1'b0;
    @(posedge clock);
    axiRead(`ADDR_MODE);
    check(rd, 32'h0);
    axiRead(8'h1c);
    check({rd[29:0], rsp}, 32'(`RESP_SLVERR));
    axiWrite(8'h1c, 32'h5);
    check(rsp, `RESP_SLVERR);
    for (int i = 0; i < 7; i++)
    begin
      axiWrite(tabAddr[i], tabData[i]);
      axiRead(tabAddr[i]);
      check(rd, tabExp[i]);
    end
    axiWrite(`ADDR_CTRL, 32'h1);
    closure(0);
    ticks(25);
    check({programRunning, 31'(advCount)}, 32'h0);
    // random bottle count, bounced first closure, two sets
    startProg(1 + int'($urandom % 4), 2, 16'h0130);
    axiRead(`ADDR_PROGRESS);
    check(rd[28:16], ovrMinutes(16'h0130));
    axiWrite(`ADDR_SPB, 32'h7);
    axiRead(`ADDR_SPB);
    check(rd, 32'h2);
    closure(3);
    waitAdv(bottlesCfg);
    ticks(30);
    check(advCount - baseAdv, bottlesCfg);
    axiRead(`ADDR_PROGRESS);
    check(rd[6:0], 7'h1);
    closure(0);
    waitIdle();
    check(advCount - baseAdv, totalSamples(bottlesCfg, 2));
    axiRead(`ADDR_STATUS);
    check(rd[4:3], 2'b10);
    // closure reloads one-minute override, expiry then samples
    startProg(1, 3, 16'h0001);
    closure(0);
    ticks(21);
    check(advCount - baseAdv, 1);
    ticks(20);
    check(advCount - baseAdv, 2);
    bottleFullIn <= 1'b1;
    ticks(6);
    check(programRunning, 1'b0);
    axiRead(`ADDR_STATUS);
    check(rd[4:3], 2'b01);
    bottleFullIn <= 1'b0;
    // slow pump: expiry inside a sequence runs right after it
    pumpBase = 25;
    startProg(1, 3, 16'h0001);
    waitAdv(2);
    check(lastGap <= 4, 1'b1);
    waitIdle();
    check(advCount - baseAdv, 3);
    // 00:00 never expires; abort ends the program at once
    startProg(2, 5, 16'h0000);
    ticks(30);
    check(advCount - baseAdv, 0);
    axiWrite(`ADDR_CTRL, 32'h2);
    check(programRunning, 1'b0);
    axiRead(`ADDR_STATUS);
    check(rd[5:0], 6'h22);
    give_verdict();
  end
endmodule // multi_bottle_composite_sequencer_tb

`default_nettype wire

/* hw/composite_sequencer.sv */
// Purpose: multi-bottle composite sampling sequencer
// Assumes: pump logic on the same clock answers sampleReq
// Notes:   registers over AXI4-Lite, one access of each kind
//
// Functional notes
// RULE1 - each debounced contact closure starts one collection sequence; the code keeps one pending start for all closures during a sequence
// RULE2 - a sequence advances spout, draws, deposits, then waits again
// RULE3 - one sample per configured bottle in each sequence
// RULE4 - samples per bottle accepted only from one to ninety-nine
// RULE5 - program ends when all sets are done or a bottle is full
// RULE6 - override countdown loads and runs from program start
// RULE7 - every closure reloads the override countdown, which keeps running
// RULE8 - countdown expiry starts a sequence just like a closure
// RULE9 - expiry during a sequence is remembered and run afterwards
// RULE10 - override time given as hours and minutes, counted in minutes
// RULE11 - composite program selected by mode code ten
// RULE12 - the instrument evaluates conditions and closes the contact
// RULE13 - contact input synchronised, debounced, one pulse per closure
`timescale 1ns/1ps
`default_nettype none
`include "sampler_map.svh"

module composite_sequencer
  import sampler_pkg::*;
#(
  parameter logic [32:0] MINUTE_CYCLES =
    33'(64'(`MINUTE_S) * 64'(`CLK_HZ)),
  parameter logic [19:0] DEBOUNCE_CYCLES =
    20'(`DEBOUNCE_MS * (`CLK_HZ / 1000))
)(
  // clock and reset
  input  wire logic     clock,
  input  wire logic     rst,
  // register bus
  input  wire axiReq_t  axiReq,
  output axiResp_t      axiResp,
  // instrument and bottle sensor pins
  input  wire logic     contactIn,
  input  wire logic     bottleFullIn,
  // pump and distributor
  input  wire logic     sampleDone,
  output logic          spoutAdvance,
  output logic          sampleReq,
  output logic [7:0]    bottleSel,
  output logic          programRunning
);

  // ========================================================
  // helpers
  function automatic logic [31:0] mergeStrb(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  function automatic logic isMapped(input logic [7:0] a);
    return a == `ADDR_CTRL || a == `ADDR_MODE || a == `ADDR_SPB ||
           a == `ADDR_BOTTLES || a == `ADDR_OVERRIDE ||
           a == `ADDR_STATUS || a == `ADDR_PROGRESS;
  endfunction

  function automatic logic [12:0] toMinutes(input logic [7:0] hr,
      input logic [7:0] mn);
    return 13'(hr * `MIN_PER_HOUR) + 13'(mn);
  endfunction

  // ========================================================
  // declarations
  logic        awHeld_q, awHeld_d, wHeld_q, wHeld_d;
  logic [7:0]  awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d;
  logic [3:0]  wStrb_q, wStrb_d;
  logic        bValid_q, bValid_d, rValid_q, rValid_d;
  logic [1:0]  bResp_q, bResp_d, rResp_q, rResp_d;
  logic [31:0] rData_q, rData_d;
  logic        wrFire;
  logic [7:0]  mode_q, mode_d, bottles_q, bottles_d;
  logic [6:0]  spb_q, spb_d;
  logic [7:0]  ovrHr_q, ovrHr_d, ovrMin_q, ovrMin_d;
  logic [31:0] wrVal;
  logic        modeSel, startReq, abortReq;
  seqState_t   state_q, state_d;
  logic [7:0]  bottle_q, bottle_d;
  logic [6:0]  sets_q, sets_d;
  logic        pend_q, pend_d, endFull_q, endFull_d, endDone_q, endDone_d;
  logic [32:0] pre_q, pre_d;
  logic [12:0] minLeft_q, minLeft_d, ovrLoad;
  logic        expire, running, trigPulse, stopNow;
  logic        bfSync1_q, bfSync2_q;

  // ========================================================
  // contact conditioning
  contact_debounce #(
    .DEBOUNCE_CYCLES (DEBOUNCE_CYCLES)
  ) contact_debounce_inst (
    .clock     (clock),
    .rst       (rst),
    .contactIn (contactIn),
    .trigPulse (trigPulse)
  );

  // bottle-full pin synchroniser
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      bfSync1_q <= 1'b0;
      bfSync2_q <= 1'b0;
    end
    else
    begin
      bfSync1_q <= bottleFullIn;
      bfSync2_q <= bfSync1_q;
    end
  end

  // ========================================================
  // bus slave: address and data taken in either order
  assign wrFire = awHeld_q && wHeld_q && !bValid_q;
  assign wrVal  = mergeStrb(32'h0, wData_q, wStrb_q);

  always_comb
  begin
    awHeld_d = awHeld_q;
    awAddr_d = awAddr_q;
    wHeld_d  = wHeld_q;
    wData_d  = wData_q;
    wStrb_d  = wStrb_q;
    bValid_d = bValid_q;
    bResp_d  = bResp_q;
    rValid_d = rValid_q;
    rResp_d  = rResp_q;
    rData_d  = rData_q;
    if (axiReq.awvalid && !awHeld_q)
    begin
      awHeld_d = 1'b1;
      awAddr_d = {axiReq.awaddr[7:2], 2'b00};
    end
    if (axiReq.wvalid && !wHeld_q)
    begin
      wHeld_d = 1'b1;
      wData_d = axiReq.wdata;
      wStrb_d = axiReq.wstrb;
    end
    if (wrFire)
    begin
      awHeld_d = 1'b0;
      wHeld_d  = 1'b0;
      bValid_d = 1'b1;
      bResp_d  = isMapped(awAddr_q) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (bValid_q && axiReq.bready)
      bValid_d = 1'b0;
    if (axiReq.arvalid && !rValid_q)
    begin
      rValid_d = 1'b1;
      rResp_d  = isMapped({axiReq.araddr[7:2], 2'b00}) ? `RESP_OKAY
                                                       : `RESP_SLVERR;
      case ({axiReq.araddr[7:2], 2'b00})
        `ADDR_MODE:     rData_d = {24'h0, mode_q};
        `ADDR_SPB:      rData_d = {25'h0, spb_q};
        `ADDR_BOTTLES:  rData_d = {24'h0, bottles_q};
        `ADDR_OVERRIDE: rData_d = {16'h0, ovrHr_q, ovrMin_q};
        `ADDR_STATUS:   rData_d = {26'h0, modeSel, endDone_q, endFull_q,
                                   pend_q, state_q != SEQ_WAIT, running};
        `ADDR_PROGRESS: rData_d = {3'h0, minLeft_q, bottle_q, 1'b0, sets_q};
        default:        rData_d = 32'h0;
      endcase
    end
    else if (rValid_q && axiReq.rready)
      rValid_d = 1'b0;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      awHeld_q <= 1'b0;
      awAddr_q <= 8'h0;
      wHeld_q  <= 1'b0;
      wData_q  <= 32'h0;
      wStrb_q  <= 4'h0;
      bValid_q <= 1'b0;
      bResp_q  <= `RESP_OKAY;
      rValid_q <= 1'b0;
      rResp_q  <= `RESP_OKAY;
      rData_q  <= 32'h0;
    end
    else
    begin
      awHeld_q <= awHeld_d;
      awAddr_q <= awAddr_d;
      wHeld_q  <= wHeld_d;
      wData_q  <= wData_d;
      wStrb_q  <= wStrb_d;
      bValid_q <= bValid_d;
      bResp_q  <= bResp_d;
      rValid_q <= rValid_d;
      rResp_q  <= rResp_d;
      rData_q  <= rData_d;
    end
  end

  assign axiResp = '{awready: !awHeld_q, wready: !wHeld_q,
                     bvalid: bValid_q, bresp: bResp_q,
                     arready: !rValid_q, rvalid: rValid_q,
                     rdata: rData_q, rresp: rResp_q};

  // ========================================================
  // keypad-style configuration, frozen while a program runs
  assign modeSel  = mode_q == `MODE_COMPOSITE; // RULE11
  assign startReq = wrFire && awAddr_q == `ADDR_CTRL &&
                    wrVal[`CTRL_START] && modeSel && !running; // RULE11
  assign abortReq = wrFire && awAddr_q == `ADDR_CTRL && wrVal[`CTRL_ABORT];

  always_comb
  begin
    mode_d    = mode_q;
    spb_d     = spb_q;
    bottles_d = bottles_q;
    ovrHr_d   = ovrHr_q;
    ovrMin_d  = ovrMin_q;
    if (wrFire && !running)
    begin
      case (awAddr_q)
        `ADDR_MODE: mode_d = wrVal[7:0];
        `ADDR_SPB:
          if (wrVal[7:0] >= 8'(`SPB_MIN) && wrVal[7:0] <= 8'(`SPB_MAX))
            spb_d = wrVal[6:0]; // RULE4
        `ADDR_BOTTLES:
          if (wrVal[7:0] != 8'h0)
            bottles_d = wrVal[7:0];
        `ADDR_OVERRIDE:
          if (wrVal[15:8] <= `HOURS_MAX && wrVal[7:0] <= `MINUTES_MAX)
          begin
            ovrHr_d  = wrVal[15:8]; // RULE10
            ovrMin_d = wrVal[7:0];
          end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      mode_q    <= 8'h0;
      spb_q     <= `SPB_RESET;
      bottles_q <= `BOTTLES_RESET;
      ovrHr_q   <= 8'h0;
      ovrMin_q  <= 8'h0;
    end
    else
    begin
      mode_q    <= mode_d;
      spb_q     <= spb_d;
      bottles_q <= bottles_d;
      ovrHr_q   <= ovrHr_d;
      ovrMin_q  <= ovrMin_d;
    end
  end

  // ========================================================
  // override countdown in whole minutes; zero time disables it
  assign running = state_q != SEQ_IDLE;
  assign ovrLoad = toMinutes(ovrHr_q, ovrMin_q); // RULE10
  assign stopNow = bfSync2_q || abortReq;

  always_comb
  begin
    pre_d     = pre_q;
    minLeft_d = minLeft_q;
    expire    = 1'b0;
    if (startReq || (running && trigPulse))
    begin
      pre_d     = 33'h0; // RULE6 RULE7
      minLeft_d = ovrLoad;
    end
    else if (running && minLeft_q != 13'h0)
    begin
      if (pre_q == MINUTE_CYCLES - 33'h1)
      begin
        pre_d = 33'h0;
        if (minLeft_q == 13'h1)
        begin
          expire    = 1'b1;
          minLeft_d = ovrLoad;
        end
        else
          minLeft_d = minLeft_q - 13'h1;
      end
      else
        pre_d = pre_q + 33'h1;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pre_q     <= 33'h0;
      minLeft_q <= 13'h0;
    end
    else
    begin
      pre_q     <= pre_d;
      minLeft_q <= minLeft_d;
    end
  end

  // ========================================================
  // collection sequencer
  always_comb
  begin
    state_d   = state_q;
    bottle_d  = bottle_q;
    sets_d    = sets_q;
    pend_d    = pend_q;
    endFull_d = endFull_q;
    endDone_d = endDone_q;
    case (state_q)
      SEQ_IDLE:
        if (startReq)
        begin
          state_d   = SEQ_WAIT;
          bottle_d  = 8'h0;
          sets_d    = 7'h0;
          pend_d    = 1'b0;
          endFull_d = 1'b0;
          endDone_d = 1'b0;
        end
      SEQ_WAIT:
        if (pend_q || trigPulse || expire) // RULE1 RULE8
        begin
          state_d  = SEQ_ADVANCE;
          bottle_d = 8'h0;
          pend_d   = 1'b0;
        end
      SEQ_ADVANCE: state_d = SEQ_DRAW; // RULE2
      SEQ_DRAW:
        if (sampleDone)
        begin
          if (bottle_q == bottles_q - 8'h1)
          begin
            sets_d = sets_q + 7'h1;
            if (sets_q + 7'h1 == spb_q) // RULE5
            begin
              state_d   = SEQ_IDLE;
              endDone_d = 1'b1;
            end
            else
              state_d = SEQ_WAIT; // RULE2
          end
          else
          begin
            bottle_d = bottle_q + 8'h1; // RULE3
            state_d  = SEQ_ADVANCE;
          end
        end
      default: state_d = SEQ_IDLE;
    endcase
    // a trigger during a sequence is kept for afterwards
    if ((state_q == SEQ_ADVANCE || state_q == SEQ_DRAW) &&
        (trigPulse || expire))
      pend_d = 1'b1; // RULE9
    if (running && stopNow)
    begin
      state_d   = SEQ_IDLE; // RULE5
      endFull_d = bfSync2_q;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_q   <= SEQ_IDLE;
      bottle_q  <= 8'h0;
      sets_q    <= 7'h0;
      pend_q    <= 1'b0;
      endFull_q <= 1'b0;
      endDone_q <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      bottle_q  <= bottle_d;
      sets_q    <= sets_d;
      pend_q    <= pend_d;
      endFull_q <= endFull_d;
      endDone_q <= endDone_d;
    end
  end

  assign spoutAdvance   = state_q == SEQ_ADVANCE;
  assign sampleReq      = state_q == SEQ_DRAW;
  assign bottleSel      = bottle_q;
  assign programRunning = running;

  // ========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_start_loads: assert property (startReq |=> // RULE6
    state_q == SEQ_WAIT && minLeft_q == $past(ovrLoad) && pre_q == 33'h0)
    else $error("start did not load the countdown");
  chk_trig_reload: assert property (running && trigPulse |=> // RULE7
    minLeft_q == $past(ovrLoad) && pre_q == 33'h0)
    else $error("closure did not reload the countdown");
  chk_trig_starts: assert property (state_q == SEQ_WAIT && trigPulse && // RULE1
    !stopNow |=> spoutAdvance ##1 (sampleReq || $past(stopNow)))
    else $error("closure did not start a sequence");
  chk_expire_starts: assert property (state_q == SEQ_WAIT && expire && // RULE8
    !stopNow |=> spoutAdvance && bottle_q == 8'h0)
    else $error("expiry did not start a sequence");
  chk_expire_kept: assert property (sampleReq && expire && // RULE9
    !stopNow |=> pend_q)
    else $error("expiry during a sequence was lost");
  chk_next_bottle: assert property (sampleReq && sampleDone && // RULE3
    bottle_q != bottles_q - 8'h1 && !stopNow |=>
    spoutAdvance && bottle_q == $past(bottle_q) + 8'h1)
    else $error("bottle not advanced by one");
  chk_full_ends: assert property (running && bfSync2_q |=> // RULE5
    state_q == SEQ_IDLE && endFull_q)
    else $error("bottle full did not end the program");
  chk_sets_end: assert property (sampleReq && sampleDone && !stopNow && // RULE5
    bottle_q == bottles_q - 8'h1 && sets_q + 7'h1 == spb_q |=>
    !running && endDone_q)
    else $error("program did not end after last set");
  chk_spb_range: assert property (spb_q >= `SPB_MIN && // RULE4
    spb_q <= `SPB_MAX)
    else $error("samples per bottle out of range");
  chk_minutes_cap: assert property (minLeft_q <= `OVR_MAX_MIN) // RULE10
    else $error("override minutes beyond limit");
  chk_mode_gate: assert property (!running ##1 running |-> // RULE11
    $past(modeSel))
    else $error("program started in another mode");

  cov_done: cover property (running ##1 !running && endDone_q);
  cov_full: cover property (running ##1 !running && endFull_q);
  cov_pend: cover property (pend_q && state_q == SEQ_WAIT);

endmodule // composite_sequencer
`default_nettype wire

/* hw/contact_debounce.sv */
// Purpose: turn the instrument contact into one trigger pulse
// Assumes: contact closed drives contactIn high
// Notes:   pulse is one cycle, on the debounced closing edge
`timescale 1ns/1ps
`default_nettype none
`include "sampler_map.svh"

module contact_debounce
  import sampler_pkg::*;
#(
  parameter logic [19:0] DEBOUNCE_CYCLES = 20'(`DEBOUNCE_MS * (`CLK_HZ / 1000))
)(
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // contact pin and trigger
  input  wire logic contactIn,
  output logic      trigPulse
);

  logic        sync1_q, sync2_q;
  logic        stable_q, stable_d;
  logic [19:0] cnt_q, cnt_d;
  logic        pulse_q, pulse_d;

  // ========================================================
  // two-stage synchroniser
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end
    else
    begin
      sync1_q <= contactIn;
      sync2_q <= sync1_q;
    end
  end

  // ========================================================
  // accept a new level only after it held for the debounce time
  always_comb
  begin
    stable_d = stable_q;
    cnt_d    = 20'h0;
    pulse_d  = 1'b0;
    if (sync2_q != stable_q)
    begin
      if (cnt_q == DEBOUNCE_CYCLES - 20'h1) // RULE13
      begin
        stable_d = sync2_q;
        pulse_d  = sync2_q; // closing edge only
      end
      else
        cnt_d = cnt_q + 20'h1;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      stable_q <= 1'b0;
      cnt_q    <= 20'h0;
      pulse_q  <= 1'b0;
    end
    else
    begin
      stable_q <= stable_d;
      cnt_q    <= cnt_d;
      pulse_q  <= pulse_d;
    end
  end

  assign trigPulse = pulse_q;

  // ========================================================
  // checks
  chk_pulse_single: assert property (@(posedge clock) disable iff (rst)
    trigPulse |=> !trigPulse) // RULE13
    else $error("trigger pulse longer than one cycle");

endmodule // contact_debounce
`default_nettype wire

/* hw/sampler_map.svh */
// Purpose: named numbers of the composite sequencer
// Assumes: 100 MHz system clock
// Notes:   definitions only
`ifndef SAMPLER_MAP_SVH
`define SAMPLER_MAP_SVH

// ==========================================================
// register offsets (byte addresses, one word each)
`define ADDR_CTRL      8'h00
`define ADDR_MODE      8'h04
`define ADDR_SPB       8'h08
`define ADDR_BOTTLES   8'h0c
`define ADDR_OVERRIDE  8'h10
`define ADDR_STATUS    8'h14
`define ADDR_PROGRESS  8'h18

// ==========================================================
// field values and limits
`define CTRL_START     0
`define CTRL_ABORT     1
`define MODE_COMPOSITE 8'h0a
`define SPB_MIN        7'h01
`define SPB_MAX        7'h63
`define SPB_RESET      7'h01
`define BOTTLES_RESET  8'h18
`define HOURS_MAX      8'h63
`define MINUTES_MAX    8'h3b
`define MIN_PER_HOUR   13'h03c
`define OVR_MAX_MIN    13'h176f
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10

// ==========================================================
// timing
`define CLK_HZ         100000000
`define MINUTE_S       60
`define DEBOUNCE_MS    10

`endif

/* hw/sampler_pkg.sv */
// Purpose: shared types of the composite sequencer
// Assumes: AXI4-Lite with 8-bit address, 32-bit data
// Notes:   numbers live in sampler_map.svh
package sampler_pkg;

  // ========================================================
  // bus carriers
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axiReq_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axiResp_t;

  // ========================================================
  // sequencer states, gray from idle through wait, advance and draw
  typedef enum logic [1:0] {
    SEQ_IDLE    = 2'b00,
    SEQ_WAIT    = 2'b01,
    SEQ_ADVANCE = 2'b11,
    SEQ_DRAW    = 2'b10
  } seqState_t;

endpackage
